// [ckc_consts.vh]
// Constants for the clock source and slow RC calibration block
`ifndef CKC_CONSTS_VH
`define CKC_CONSTS_VH
`define CKC_ADDR_CLOCK_CONTROL 8'hc6
`define CKC_ADDR_CLOCK_STATUS  8'hc7
`define CKC_ADDR_SLEEP_REQ     8'hc8
`define CKC_ADDR_RATE_LIMIT    8'hc9
`define CKC_BIT_SLOW_SEL       7
`define CKC_BIT_SYS_SEL        6
`define CKC_RST_CLOCK_CONTROL  8'hc9
`define CKC_CAL_TIME_US        2000
`define CKC_ABORT_TIME_US      130
`define CKC_CLK_MHZ            50
`define CKC_CAL_CYCLES         (`CKC_CAL_TIME_US * `CKC_CLK_MHZ)
`define CKC_ABORT_CYCLES       (`CKC_ABORT_TIME_US * `CKC_CLK_MHZ)
`define CKC_DIV_NARROW_XTAL    11'd750
`define CKC_DIV_WIDE_XTAL      11'd1500
`endif

// [ckc_clock_control.v]
// Clock source selection and slow RC calibration sequencer
//
// Functional notes
// - Without error correction, divider setting limits maximum radio data rate
// - Calibrated RC runs at crystal over 750/1500
// - Calibration needs RC running, crystal stable
// - Never run both slow oscillators together
// - Reset enables and selects slow RC oscillator
// - Crystal selection starts repeated RC calibration
// - One calibration pass lasts about 2 ms
// - Later calibrations abort on switch or sleep
// - Initial calibration finishes before request acts
// - After initial, act about 130 us later
// - Slow select bit 7, reset 1
// - Slow select returns to 1 after deep sleep
// - System select bit 6, reset 1
// - Switch clock only after oscillator stable
`timescale 1ns/10ps
`default_nettype none
`include "ckc_consts.vh"
module ckc_clock_control #(
	parameter CAL_CYCLES   = `CKC_CAL_CYCLES,
	parameter ABORT_CYCLES = `CKC_ABORT_CYCLES,
	parameter WIDE_XTAL    = 0
) (
	// Clock and reset
	input  wire       clk_sys,
	input  wire       rstn,
	// Register port
	input  wire [7:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_wr,
	input  wire       reg_rd,
	output reg  [7:0] reg_rdata,
	// Oscillator status
	input  wire       crystal_stable_flag,
	input  wire       rc_fast_stable,
	input  wire       slow_rc_running,
	input  wire       wake_from_deep,
	// Oscillator control
	output reg        sys_clk_on_crystal,
	output reg        fast_crystal_en,
	output reg        fast_rc_en,
	output reg        slow_rc_en,
	output reg        slow_xtal_en,
	output reg        cal_active,
	output reg        sleep_enter,
	output reg [1:0]  sleep_mode,
	output reg [10:0] slow_rc_divisor
);
	localparam ST_IDLE  = 2'd0;
	localparam ST_CAL   = 2'd1;
	localparam ST_ABORT = 2'd2;
	localparam [23:0] CAL_LAST   = CAL_CYCLES[23:0] - 24'h000001;
	localparam [23:0] ABORT_LAST = ABORT_CYCLES[23:0] - 24'h000001;
	localparam [10:0] DIV_SEL    = WIDE_XTAL ? `CKC_DIV_WIDE_XTAL : `CKC_DIV_NARROW_XTAL;

	reg  [7:0]  ctl_q;
	reg  [1:0]  st_q;
	reg  [23:0] cnt_q;
	reg         init_done_q;
	reg         pend_q;
	reg         pend_sleep_q;
	reg  [1:0]  pend_mode_q;
	reg         switch_rc_q;
	reg         error_corr_q;
	reg  [1:0]  mod_fmt_q;

	wire sel_rc   = ctl_q[`CKC_BIT_SYS_SEL];
	wire wr_ctl   = reg_wr && reg_addr == `CKC_ADDR_CLOCK_CONTROL;
	wire wr_sleep = reg_wr && reg_addr == `CKC_ADDR_SLEEP_REQ;
	wire wr_rate  = reg_wr && reg_addr == `CKC_ADDR_RATE_LIMIT;
	wire req_rc   = wr_ctl && !sel_rc && reg_wdata[`CKC_BIT_SYS_SEL];
	wire req_slp  = wr_sleep && reg_wdata[1:0] != 2'b00;
	wire req_any  = req_rc || req_slp;
	wire cal_ok   = slow_rc_running && crystal_stable_flag && fast_crystal_en;
	wire cal_last   = cnt_q >= CAL_LAST;
	wire abort_last = cnt_q >= ABORT_LAST;
	wire in_idle    = st_q == ST_IDLE;
	wire act_now    = in_idle && (pend_q || (req_any && !sel_rc) || req_slp);
	wire act_sleep  = pend_q ? pend_sleep_q : req_slp;
	wire [1:0] act_mode = pend_q ? pend_mode_q : reg_wdata[1:0];
	wire cal_start  = in_idle && !act_now && !sel_rc && !switch_rc_q
		&& ctl_q[`CKC_BIT_SLOW_SEL] && cal_ok;

	// Maximum baud in kBaud for divider and format (0 MSK, 1 GFSK, 2 2-FSK)
	function [9:0] max_kbaud;
		input [2:0] div;
		input [1:0] fmt;
		begin
			case (div)
			3'h0, 3'h1, 3'h2, 3'h3: max_kbaud = (fmt == 2'd1) ? 10'd250 : 10'd500;
			3'h4: max_kbaud = (fmt == 2'd1) ? 10'd250 : 10'd400;
			3'h5: max_kbaud = 10'd200;
			3'h6: max_kbaud = 10'd100;
			default: max_kbaud = 10'd50;
			endcase
		end
	endfunction

	wire [2:0] div_eff = error_corr_q ? 3'h0 : ctl_q[2:0];
	wire [9:0] rate_kbaud = max_kbaud(div_eff, mod_fmt_q);
	wire [9:0] rate_half  = rate_kbaud >> 1;

	// Control register
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ctl_q <= `CKC_RST_CLOCK_CONTROL;
		end else if (wake_from_deep) begin
			ctl_q[`CKC_BIT_SLOW_SEL] <= 1'b1;
		end else if (wr_ctl) begin
			ctl_q[5:0] <= reg_wdata[5:0];
			if (sel_rc)
				ctl_q[`CKC_BIT_SLOW_SEL] <= reg_wdata[`CKC_BIT_SLOW_SEL];
			if (!reg_wdata[`CKC_BIT_SYS_SEL])
				ctl_q[`CKC_BIT_SYS_SEL] <= 1'b0;
		end else if (switch_rc_q && rc_fast_stable) begin
			ctl_q[`CKC_BIT_SYS_SEL] <= 1'b1;
		end
	end

	// Rate limit configuration
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			error_corr_q <= 1'b0;
			mod_fmt_q <= 2'd0;
		end else if (wr_rate) begin
			error_corr_q <= reg_wdata[7];
			mod_fmt_q <= reg_wdata[1:0];
		end
	end

	// Calibration state and pass counter
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			st_q <= ST_IDLE;
			cnt_q <= 24'h000000;
		end else begin
			case (st_q)
			ST_IDLE: begin
				if (cal_start) begin
					st_q <= ST_CAL;
					cnt_q <= 24'h000000;
				end
			end
			ST_CAL: begin
				if (sel_rc || !cal_ok) begin
					st_q <= ST_IDLE;
					cnt_q <= 24'h000000;
				end else if (init_done_q && (req_any || pend_q)) begin
					st_q <= ST_ABORT;
					cnt_q <= 24'h000000;
				end else if (cal_last) begin
					cnt_q <= 24'h000000;
					if (pend_q) begin
						st_q <= ST_IDLE;
					end
				end else begin
					cnt_q <= cnt_q + 24'h000001;
				end
			end
			ST_ABORT: begin
				if (abort_last) begin
					st_q <= ST_IDLE;
					cnt_q <= 24'h000000;
				end else begin
					cnt_q <= cnt_q + 24'h000001;
				end
			end
			default: begin
				st_q <= ST_IDLE;
				cnt_q <= 24'h000000;
			end
			endcase
		end
	end

	// Initial calibration finished flag
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			init_done_q <= 1'b0;
		end else begin
			if (sel_rc && !switch_rc_q) begin
				init_done_q <= 1'b0;
			end else if (st_q == ST_CAL && cal_ok && !sel_rc && cal_last) begin
				init_done_q <= 1'b1;
			end
		end
	end

	// Pending switch or sleep request
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pend_q <= 1'b0;
			pend_sleep_q <= 1'b0;
			pend_mode_q <= 2'b00;
		end else begin
			if (act_now) begin
				pend_q <= 1'b0;
			end else if (req_any && !pend_q) begin
				pend_q <= 1'b1;
				pend_sleep_q <= req_slp;
				pend_mode_q <= reg_wdata[1:0];
			end
		end
	end

	// Switch back to fast RC oscillator
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			switch_rc_q <= 1'b0;
		end else begin
			if (act_now && !act_sleep) begin
				switch_rc_q <= 1'b1;
			end else if (switch_rc_q && rc_fast_stable && !wr_ctl) begin
				switch_rc_q <= 1'b0;
			end
		end
	end

	// Sleep entry pulse
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			sleep_enter <= 1'b0;
			sleep_mode <= 2'b00;
		end else begin
			sleep_enter <= act_now && act_sleep;
			if (act_now && act_sleep) begin
				sleep_mode <= act_mode;
			end
		end
	end

	// Oscillator enables
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			fast_crystal_en <= 1'b0;
			fast_rc_en <= 1'b1;
			slow_rc_en <= 1'b1;
			slow_xtal_en <= 1'b0;
		end else begin
			fast_crystal_en <= !sel_rc;
			fast_rc_en <= sel_rc || switch_rc_q;
			slow_rc_en <= ctl_q[`CKC_BIT_SLOW_SEL];
			slow_xtal_en <= !ctl_q[`CKC_BIT_SLOW_SEL];
		end
	end

	// System clock source
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			sys_clk_on_crystal <= 1'b0;
		end else begin
			sys_clk_on_crystal <= !sel_rc && crystal_stable_flag;
		end
	end

	// Calibration status and divisor
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cal_active <= 1'b0;
			slow_rc_divisor <= DIV_SEL;
		end else begin
			cal_active <= st_q == ST_CAL;
			slow_rc_divisor <= DIV_SEL;
		end
	end

	// Read data
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= 8'h00;
			if (reg_rd) begin
				case (reg_addr)
				`CKC_ADDR_CLOCK_CONTROL: begin
					reg_rdata <= ctl_q;
				end
				`CKC_ADDR_CLOCK_STATUS: begin
					reg_rdata <= {4'h0, pend_q, init_done_q, st_q};
				end
				`CKC_ADDR_RATE_LIMIT: begin
					reg_rdata <= rate_half[7:0];
				end
				default: begin
					reg_rdata <= 8'h00;
				end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// [ckc_clock_control_properties.sv]
// Port checker for the clock source control block
`timescale 1ns/10ps
`default_nettype none
module ckc_clock_control_chk #(
	parameter WIDE_XTAL = 0
) (
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        rstn,
	// Oscillator status and control
	input wire logic        crystal_stable_flag,
	input wire logic        sys_clk_on_crystal,
	input wire logic        fast_crystal_en,
	input wire logic        fast_rc_en,
	input wire logic        slow_rc_en,
	input wire logic        slow_xtal_en,
	input wire logic        cal_active,
	input wire logic [10:0] slow_rc_divisor
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	property p_excl; !(slow_rc_en && slow_xtal_en); endproperty
	a_excl: assert property (p_excl) else $error("slow osc overlap");
	property p_div; slow_rc_divisor == (WIDE_XTAL ? 11'h5dc : 11'h2ee); endproperty
	a_div: assert property (p_div) else $error("bad divisor");
	property p_rst7; $rose(rstn) |-> slow_rc_en && !slow_xtal_en; endproperty
	a_rst7: assert property (p_rst7) else $error("slow rc off at reset");
	property p_rst18; $rose(rstn) |-> fast_rc_en && !sys_clk_on_crystal; endproperty
	a_rst18: assert property (p_rst18) else $error("sys clk not rc at reset");
	property p_cal; cal_active |-> fast_crystal_en; endproperty
	a_cal: assert property (p_cal) else $error("cal without crystal");
	property p_stb; $rose(sys_clk_on_crystal) |-> $past(crystal_stable_flag); endproperty
	a_stb: assert property (p_stb) else $error("switch before stable");
	property p_xen; sys_clk_on_crystal |-> fast_crystal_en; endproperty
	a_xen: assert property (p_xen) else $error("crystal clock unpowered");
	property p_sel; $changed(slow_xtal_en) |-> !$past(sys_clk_on_crystal); endproperty
	a_sel: assert property (p_sel) else $error("slow select on crystal");
endmodule
bind ckc_clock_control ckc_clock_control_chk #(.WIDE_XTAL(WIDE_XTAL)) u_chk (
	.clk_sys(clk_sys), .rstn(rstn), .crystal_stable_flag(crystal_stable_flag),
	.sys_clk_on_crystal(sys_clk_on_crystal), .fast_crystal_en(fast_crystal_en),
	.fast_rc_en(fast_rc_en), .slow_rc_en(slow_rc_en), .slow_xtal_en(slow_xtal_en),
	.cal_active(cal_active), .slow_rc_divisor(slow_rc_divisor));
`default_nettype wire

// [test_ckc_clock_control.sv]
// Self-checking bench for the clock source control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, v) begin num_checks++; if ((v) !== (e)) begin fails++; \
	$display("[FAIL] %s expected %h seen %h", n, e, v); end end
`define WT(c, n) for (i = 0; i < n && !(c); i++) begin @(posedge clk_sys); #1; end
module test_ckc_clock_control;
	logic        clk_sys, rstn, reg_wr, reg_rd, xstb, wake;
	logic [7:0]  reg_addr, reg_wdata;
	wire  [7:0]  reg_rdata;
	wire         on_xtal, xen, rcen, src_en, sxen, cal, slp;
	wire  [1:0]  smode;
	wire  [10:0] div;
	int          fails, num_checks, cyc, i;
	ckc_clock_control #(.CAL_CYCLES(50), .ABORT_CYCLES(10), .WIDE_XTAL(0)) u_dut (
		.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.crystal_stable_flag(xstb), .rc_fast_stable(1'b1), .slow_rc_running(1'b1),
		.wake_from_deep(wake), .sys_clk_on_crystal(on_xtal), .fast_crystal_en(xen),
		.fast_rc_en(rcen), .slow_rc_en(src_en), .slow_xtal_en(sxen), .cal_active(cal),
		.sleep_enter(slp), .sleep_mode(smode), .slow_rc_divisor(div));
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	task give_verdict;
		$display("Checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			give_verdict;
		end
	end
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e, input string n);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 `CHK(n, e, reg_rdata)
	endtask
	initial begin
		rstn = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		xstb = 1'b0;
		wake = 1'b0;
		repeat (6) @(posedge clk_sys);
		rstn <= 1'b1;
		rd(8'hc6, 8'hc9, "ctrl_reset");
		wr(8'hc6, 8'h49);
		rd(8'hc6, 8'h49, "slow_sel");
		`CHK("slow_en", 2'b01, {src_en, sxen})
		wake <= 1'b1;
		@(posedge clk_sys);
		wake <= 1'b0;
		rd(8'hc6, 8'hc9, "slow_wake");
		wr(8'hc9, 8'h01);
		rd(8'hc9, 8'h7d, "rate_gfsk");
		wr(8'hc6, 8'hcd);
		wr(8'hc9, 8'h02);
		rd(8'hc9, 8'h64, "rate_div5");
		wr(8'hc9, 8'h82);
		rd(8'hc9, 8'hfa, "rate_fec");
		$display("Test registers done");
		wr(8'hc6, 8'h8d);
		repeat (5) @(posedge clk_sys);
		#1 `CHK("wait_stable", 1'b0, on_xtal)
		xstb <= 1'b1;
		`WT(cal, 10)
		`CHK("cal_start", 2'b11, {cal, on_xtal})
		wr(8'hc6, 8'hcd);
		repeat (5) @(posedge clk_sys);
		#1 `CHK("deferred", 1'b1, on_xtal)
		`WT(!on_xtal, 60)
		`CHK("switched", 1'b0, on_xtal)
		$display("Test initial calibration done");
		wr(8'hc6, 8'h8d);
		repeat (80) @(posedge clk_sys);
		wr(8'hc8, 8'h01);
		`WT(slp, 40)
		`CHK("sleep_pulse", 1'b1, slp)
		`CHK("sleep_mode", 2'h1, smode)
		`CHK("abort_delay", 1'b1, i > 5)
		$display("Test abort done");
		give_verdict;
	end
endmodule
`default_nettype wire
